// [verilog/asramc_pkg.sv]
// Package for the asynchronous static memory word-port controller.
// Assumes a 20 MHz mclk; all pin timings are counted in whole mclk cycles.
package asramc_pkg;
    // ==========================================================
    // Widths
    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;
    localparam int LANE_W = 8;
    // ==========================================================
    // Clock and pin timings
    localparam int CLK_PERIOD_NS = 50;
    localparam int CLK_MHZ = 20;
    localparam int T_POWER_US = 100;       // Supply stable to first access
    localparam int T_RC_NS = 8;            // Least read cycle
    localparam int T_AA_NS = 8;            // Address to data valid
    localparam int T_WC_NS = 8;            // Least write cycle
    localparam int T_PWE_NS = 6;           // Strobe pulse, also select and lane hold
    localparam int T_SD_NS = 4;            // Data setup to write end
    localparam int T_HZWE_NS = 4;          // Strobe low to float
    localparam int T_HZOE_NS = 4;          // Output enable high to float
    // Least times round up, never below one cycle
    function automatic int ceilCycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : ceilCycles
    localparam int POWER_CYCLES = T_POWER_US * CLK_MHZ;
    localparam int SYNC_STAGES = 2;        // Flops between the data pins and the read register
    // Access time plus the synchroniser, so read data is settled when it is taken
    localparam int READ_CYCLES = ceilCycles((T_AA_NS > T_RC_NS) ? T_AA_NS : T_RC_NS) + SYNC_STAGES;
    localparam int WRITE_CYCLES = ceilCycles(T_PWE_NS + T_SD_NS + T_HZWE_NS + T_WC_NS);
    localparam int FLOAT_CYCLES = ceilCycles(T_HZOE_NS);
    localparam int CNT_W = 12;
    // ==========================================================
    // Controller states
    typedef enum logic [2:0] {
        ASRAMC_POWER = 3'b000,
        ASRAMC_IDLE  = 3'b001,
        ASRAMC_READ  = 3'b010,
        ASRAMC_WRITE = 3'b011,
        ASRAMC_RECOV = 3'b100
    } asramc_state_t;
endpackage : asramc_pkg

// [verilog/asramc_sync.sv]
// Two-flop synchroniser for a bus of pin inputs.
// Assumes the input is asynchronous to mclk; only stage two is read outside.
`timescale 1ns/10ps
module asramc_sync #(
    parameter int W = 16
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    // ==========================================================
    // Stages
    logic [W-1:0] stage1; // Only read by stage two
    logic [W-1:0] next_stage1;
    logic [W-1:0] next_dout;
    // Next values are just a shift
    always_comb begin
        next_stage1 = din;
        next_dout = stage1;
    end
    // Register both stages
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            stage1 <= '0;
            dout <= '0;
        end else begin
            stage1 <= next_stage1;
            dout <= next_dout;
        end
    end
endmodule : asramc_sync

// [verilog/asramc_ctrl.sv]
// Host-side controller for a 256K x 16 asynchronous static memory.
// Assumes a user port on mclk and the memory pins wired directly to this block.
//
// Behaviour
// - Drive 18-bit word address per access
// - Write spans overlap of select, strobe, lanes
// - Write data valid before ending edge
// - Wait 100 us before first access
// - Read cycle long enough for data
// - Write cycle and pulses held long enough
// - Address stable around the write
// - Strobe-ended write with OE low lengthened
// - Address valid by select falling edge
`timescale 1ns/10ps
module asramc_ctrl (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic reqValid,              // Request strobe, one cycle
    input wire logic reqWrite,              // One for write
    input wire logic [17:0] reqAddr,
    input wire logic [15:0] reqWdata,
    input wire logic [1:0] reqLaneEn,       // Bit1 upper, bit0 lower, active high
    output logic reqReady,                  // High when a request is taken
    output logic rspValid,                  // One-cycle pulse at end of access
    output logic [15:0] rspRdata,
    output logic [17:0] word_address,
    output logic chipSelect_n,
    output logic writeStrobe_n,
    output logic outputEnable_n,
    output logic upper_byte_enable_n,
    output logic lower_byte_enable_n,
    output logic [15:0] dataBusOut,
    output logic [15:0] dataBusOe_n,        // Low while this block drives the bus
    input wire logic [15:0] data_bus
);
    // ==========================================================
    // Synchronised read data
    logic [15:0] busSync;
    asramc_sync #(.W(asramc_pkg::DATA_W)) uSync (
        .mclk(mclk),
        .arst_n(arst_n),
        .din(data_bus),
        .dout(busSync)
    );
    // ==========================================================
    // State
    asramc_pkg::asramc_state_t state, next_state;
    logic [asramc_pkg::CNT_W-1:0] cnt, next_cnt; // Phase counter
    logic [1:0] lanes, next_lanes;               // Lanes of current access
    logic next_reqReady, next_rspValid;
    logic [15:0] next_rspRdata, next_dataBusOut, next_dataBusOe_n;
    logic [17:0] next_word_address;
    logic next_cs_n, next_we_n, next_oe_n, next_ube_n, next_lbe_n;

    // Counter reload values at fixed width
    localparam logic [asramc_pkg::CNT_W-1:0] POWER_LOAD = asramc_pkg::CNT_W'(asramc_pkg::POWER_CYCLES - 1);
    localparam logic [asramc_pkg::CNT_W-1:0] READ_LOAD = asramc_pkg::CNT_W'(asramc_pkg::READ_CYCLES - 1);
    localparam logic [asramc_pkg::CNT_W-1:0] WRITE_LOAD = asramc_pkg::CNT_W'(asramc_pkg::WRITE_CYCLES - 1);
    localparam logic [asramc_pkg::CNT_W-1:0] FLOAT_LOAD = asramc_pkg::CNT_W'(asramc_pkg::FLOAT_CYCLES - 1);
    localparam logic [asramc_pkg::CNT_W-1:0] CNT_ZERO = 12'h000;
    localparam logic [asramc_pkg::CNT_W-1:0] CNT_ONE = 12'h001;

    // Lane mask expanded to the bus
    function automatic logic [15:0] laneMask(input logic [1:0] l);
        return {{asramc_pkg::LANE_W{l[1]}}, {asramc_pkg::LANE_W{l[0]}}};
    endfunction : laneMask

    // ==========================================================
    // Next-state logic
    // Every pin change lands on an mclk edge; at 50 ns a cycle each phase
    // is far longer than any pin timing, trading speed for simplicity.
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_lanes = lanes;
        next_reqReady = 1'b0;
        next_rspValid = 1'b0;
        next_rspRdata = rspRdata;
        next_word_address = word_address;
        next_cs_n = chipSelect_n;
        next_we_n = writeStrobe_n;
        next_oe_n = outputEnable_n;
        next_ube_n = upper_byte_enable_n;
        next_lbe_n = lower_byte_enable_n;
        next_dataBusOut = dataBusOut;
        next_dataBusOe_n = dataBusOe_n;
        case (state)
            // Pins stay idle through the whole wait; no request is seen here
            asramc_pkg::ASRAMC_POWER: begin
                // No access until the power-up wait has run out
                if (cnt == CNT_ZERO) begin
                    next_state = asramc_pkg::ASRAMC_IDLE;
                    next_reqReady = 1'b1;
                end else begin
                    next_cnt = cnt - CNT_ONE;
                end
            end
            asramc_pkg::ASRAMC_IDLE: begin
                next_reqReady = 1'b1;
                // Requests with no lane enabled are ignored
                if (reqValid && reqReady && (reqLaneEn != 2'h0)) begin
                    next_reqReady = 1'b0;
                    next_lanes = reqLaneEn;
                    // Address goes out with select, never after it
                    next_word_address = reqAddr;
                    next_cs_n = 1'b0;
                    next_ube_n = ~reqLaneEn[1];
                    next_lbe_n = ~reqLaneEn[0];
                    if (reqWrite) begin
                        // OE stays high so the device never drives during write
                        next_we_n = 1'b0;
                        next_oe_n = 1'b1;
                        next_dataBusOut = reqWdata;
                        next_dataBusOe_n = ~laneMask(reqLaneEn);
                        next_cnt = WRITE_LOAD;
                        next_state = asramc_pkg::ASRAMC_WRITE;
                    end else begin
                        next_we_n = 1'b1;
                        next_oe_n = 1'b0;
                        next_dataBusOe_n = 16'hFFFF;
                        next_cnt = READ_LOAD;
                        next_state = asramc_pkg::ASRAMC_READ;
                    end
                end
            end
            asramc_pkg::ASRAMC_READ: begin
                if (cnt == CNT_ZERO) begin
                    // Data has crossed both synchroniser stages by now; READ_LOAD
                    // holds two cycles on top of the access time for that.
                    next_rspRdata = busSync & laneMask(lanes);
                    next_rspValid = 1'b1;
                    next_cs_n = 1'b1;
                    next_oe_n = 1'b1;
                    next_ube_n = 1'b1;
                    next_lbe_n = 1'b1;
                    next_cnt = FLOAT_LOAD;
                    next_state = asramc_pkg::ASRAMC_RECOV;
                end else begin
                    next_cnt = cnt - CNT_ONE;
                end
            end
            // Strobe low for one phase; 50 ns covers pulse, setup and float
            asramc_pkg::ASRAMC_WRITE: begin
                if (cnt == CNT_ZERO) begin
                    // Strobe ends the write; data, address and select stay one more phase
                    next_we_n = 1'b1;
                    next_rspValid = 1'b1;
                    next_cnt = FLOAT_LOAD;
                    next_state = asramc_pkg::ASRAMC_RECOV;
                end else begin
                    next_cnt = cnt - CNT_ONE;
                end
            end
            // One idle phase lets the device release the bus before the next turn
            asramc_pkg::ASRAMC_RECOV: begin
                // Release everything, then let device output float before next turn
                next_cs_n = 1'b1;
                next_ube_n = 1'b1;
                next_lbe_n = 1'b1;
                next_dataBusOe_n = 16'hFFFF;
                if (cnt == CNT_ZERO) begin
                    next_state = asramc_pkg::ASRAMC_IDLE;
                    next_reqReady = 1'b1;
                end else begin
                    next_cnt = cnt - CNT_ONE;
                end
            end
            default: begin
                next_state = asramc_pkg::ASRAMC_IDLE;
            end
        endcase
    end

    // ==========================================================
    // Registers; all pins come straight from flops
    // Reset leaves every strobe high so the device sits in standby
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state <= asramc_pkg::ASRAMC_POWER;
            cnt <= POWER_LOAD;
            lanes <= 2'h0;
            reqReady <= 1'b0;
            rspValid <= 1'b0;
            rspRdata <= 16'h0000;
            word_address <= 18'h00000;
            chipSelect_n <= 1'b1;
            writeStrobe_n <= 1'b1;
            outputEnable_n <= 1'b1;
            upper_byte_enable_n <= 1'b1;
            lower_byte_enable_n <= 1'b1;
            dataBusOut <= 16'h0000;
            dataBusOe_n <= 16'hFFFF;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            lanes <= next_lanes;
            reqReady <= next_reqReady;
            rspValid <= next_rspValid;
            rspRdata <= next_rspRdata;
            word_address <= next_word_address;
            chipSelect_n <= next_cs_n;
            writeStrobe_n <= next_we_n;
            outputEnable_n <= next_oe_n;
            upper_byte_enable_n <= next_ube_n;
            lower_byte_enable_n <= next_lbe_n;
            dataBusOut <= next_dataBusOut;
            dataBusOe_n <= next_dataBusOe_n;
        end
    end
endmodule : asramc_ctrl

// [tb/asramc_mem_model.sv]
// Behavioural 256K x 16 static memory that answers the controller pins.
// Assumes zero pin delays; the bench resolves the shared data wire.
`timescale 1ns/10ps
module asramc_mem_model (
    input wire logic chipSelect_n,
    input wire logic writeStrobe_n,
    input wire logic outputEnable_n,
    input wire logic upper_byte_enable_n,
    input wire logic lower_byte_enable_n,
    input wire logic [17:0] word_address,
    input wire logic [15:0] data_bus,
    output logic [15:0] memOut,
    output logic [1:0] memDrive
);
    // ==========================================================
    // Storage
    logic [15:0] mem [0:262143]; // One word per address
    logic rdOn; // Selected read with outputs on
    // Level write while selected and strobed; a write ends on the first rise
    always @* begin
        if (!chipSelect_n && !writeStrobe_n) begin
            if (!lower_byte_enable_n) mem[word_address][7:0] = data_bus[7:0];
            if (!upper_byte_enable_n) mem[word_address][15:8] = data_bus[15:8];
        end
    end
    // Drive only in a selected, enabled read; otherwise float
    assign rdOn = !chipSelect_n && writeStrobe_n && !outputEnable_n;
    assign memDrive = {rdOn && !upper_byte_enable_n, rdOn && !lower_byte_enable_n};
    assign memOut = mem[word_address];
endmodule : asramc_mem_model

// [tb/asramc_ctrl_monitor.sv]
// Pin and user-port checker for the static memory controller.
// Assumes it is bound into asramc_ctrl and sees only its ports.
`timescale 1ns/10ps
module asramc_ctrl_monitor (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic [17:0] reqAddr,
    input wire logic [15:0] reqWdata,
    input wire logic [1:0] reqLaneEn,
    input wire logic reqReady,
    input wire logic rspValid,
    input wire logic [17:0] word_address,
    input wire logic chipSelect_n,
    input wire logic writeStrobe_n,
    input wire logic outputEnable_n,
    input wire logic upper_byte_enable_n,
    input wire logic lower_byte_enable_n,
    input wire logic [15:0] dataBusOut,
    input wire logic [15:0] dataBusOe_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // ==========================================================
    // Helpers
    logic take; // Request accepted at this edge
    logic [11:0] pwrCnt; // Cycles since reset, saturating
    logic [11:0] next_pwrCnt;
    assign take = reqValid && reqReady && (reqLaneEn != 2'h0);
    always_comb next_pwrCnt = (pwrCnt == 12'hFFF) ? pwrCnt : pwrCnt + 12'h001;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) pwrCnt <= 12'h000;
        else pwrCnt <= next_pwrCnt;
    end
    sequence sRdTake; take && !reqWrite; endsequence
    sequence sWrTake; take && reqWrite; endsequence
    sequence sWrPulse; (!chipSelect_n && !writeStrobe_n) ##1 (!chipSelect_n && writeStrobe_n) ##1 chipSelect_n; endsequence
    // ==========================================================
    // Assertions
    chk_power_wait: assert property (pwrCnt < 12'h7CF |-> !reqReady && chipSelect_n)
        else $error("access before power wait");
    chk_rd_strobes: assert property (sRdTake |=> !chipSelect_n && !outputEnable_n && writeStrobe_n)
        else $error("read strobes wrong");
    chk_rd_resp: assert property (sRdTake |-> ##4 rspValid)
        else $error("read answer late");
    chk_wr_shape: assert property (sWrTake |=> sWrPulse)
        else $error("write pulse shape wrong");
    chk_wr_resp: assert property (sWrTake |-> ##2 rspValid)
        else $error("write answer late");
    chk_wr_data: assert property (sWrTake |=> dataBusOut == $past(reqWdata) && word_address == $past(reqAddr))
        else $error("write data or address wrong");
    chk_lane_map: assert property (take |=> upper_byte_enable_n == !$past(reqLaneEn[1])
        && lower_byte_enable_n == !$past(reqLaneEn[0])
        && dataBusOe_n == {{8{!$past(reqWrite && reqLaneEn[1])}}, {8{!$past(reqWrite && reqLaneEn[0])}}})
        else $error("lane mapping wrong");
    chk_addr_hold: assert property (!chipSelect_n && $past(!chipSelect_n) |-> $stable(word_address))
        else $error("address moved in access");
    chk_oe_write: assert property (!writeStrobe_n |-> outputEnable_n && !chipSelect_n)
        else $error("output enable low in write");
    chk_no_fight: assert property (!outputEnable_n |-> &dataBusOe_n)
        else $error("bus driven in read");
endmodule : asramc_ctrl_monitor
bind asramc_ctrl asramc_ctrl_monitor u_mon (.mclk(mclk), .arst_n(arst_n), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqAddr(reqAddr), .reqWdata(reqWdata), .reqLaneEn(reqLaneEn), .reqReady(reqReady), .rspValid(rspValid),
    .word_address(word_address), .chipSelect_n(chipSelect_n), .writeStrobe_n(writeStrobe_n),
    .outputEnable_n(outputEnable_n), .upper_byte_enable_n(upper_byte_enable_n), .dataBusOut(dataBusOut),
    .lower_byte_enable_n(lower_byte_enable_n), .dataBusOe_n(dataBusOe_n));

// [tb/testbench.sv]
// Self-checking bench for the static memory controller.
// Assumes the memory model and the checker are compiled first.
`timescale 1ns/10ps
module testbench;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic reqValid = 1'b0;
    logic reqWrite = 1'b0;
    logic [17:0] reqAddr = 18'h00000;
    logic [15:0] reqWdata = 16'h0000;
    logic [1:0] reqLaneEn = 2'h0;
    logic reqReady, rspValid, chipSelect_n, writeStrobe_n, outputEnable_n, upper_byte_enable_n, lower_byte_enable_n;
    logic [15:0] rspRdata, dataBusOut, dataBusOe_n, memOut, dataBus, rd;
    logic [15:0] junk = 16'h0000; // Floating wire changes every cycle
    logic [17:0] word_address;
    logic [1:0] memDrive;
    int error_cnt = 0;
    int tests_run = 0;
    always #25 mclk = ~mclk;
    always @(posedge mclk) junk <= ~junk;
    // Wire level: controller first, then memory, else floating
    always_comb begin
        for (int i = 0; i < 16; i++)
            dataBus[i] = !dataBusOe_n[i] ? dataBusOut[i] : (memDrive[i/8] ? memOut[i] : junk[i]);
    end
    asramc_ctrl dut (.mclk(mclk), .arst_n(arst_n), .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
        .reqWdata(reqWdata), .reqLaneEn(reqLaneEn), .reqReady(reqReady), .rspValid(rspValid), .rspRdata(rspRdata),
        .word_address(word_address), .chipSelect_n(chipSelect_n), .writeStrobe_n(writeStrobe_n),
        .outputEnable_n(outputEnable_n), .upper_byte_enable_n(upper_byte_enable_n),
        .lower_byte_enable_n(lower_byte_enable_n), .dataBusOut(dataBusOut), .dataBusOe_n(dataBusOe_n), .data_bus(dataBus));
    asramc_mem_model mem (.chipSelect_n(chipSelect_n), .writeStrobe_n(writeStrobe_n), .outputEnable_n(outputEnable_n),
        .upper_byte_enable_n(upper_byte_enable_n), .lower_byte_enable_n(lower_byte_enable_n),
        .word_address(word_address), .data_bus(dataBus), .memOut(memOut), .memDrive(memDrive));
    // ==========================================================
    // Shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run;
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : complete_run
    // Step one cycle; a wait that runs out ends the run
    task automatic step(inout int n);
        @(posedge mclk);
        #1;
        n++;
        if (n > 3000) begin
            check(16'hDEAD, 16'h0000);
            complete_run;
        end
    endtask : step
    // One request held until taken, then the answer
    task automatic access(input logic wr, input logic [17:0] a, input logic [15:0] d, input logic [1:0] ln,
        output logic [15:0] q);
        int n;
        n = 0;
        while (reqReady !== 1'b1) step(n);
        reqValid = 1'b1;
        reqWrite = wr;
        reqAddr = a;
        reqWdata = d;
        reqLaneEn = ln;
        step(n);
        reqValid = 1'b0;
        n = 2980;
        while (rspValid !== 1'b1) step(n);
        q = rspRdata;
    endtask : access
    // ==========================================================
    // Scenarios
    task automatic t_power;
        int n;
        n = 0;
        while (reqReady !== 1'b1) step(n);
        check(16'(n >= 2000 && n <= 2003), 16'h0001);
    endtask : t_power
    task automatic t_words;
        logic [17:0] a [3] = '{18'h00000, 18'h00001, 18'h3FFFF};
        for (int i = 0; i < 3; i++) access(1'b1, a[i], a[i][15:0] ^ 16'hC3A5, 2'h3, rd);
        for (int i = 0; i < 3; i++) begin
            access(1'b0, a[i], 16'h0000, 2'h3, rd);
            check(rd, a[i][15:0] ^ 16'hC3A5);
        end
    endtask : t_words
    task automatic t_lanes;
        access(1'b1, 18'h00155, 16'h1234, 2'h3, rd);
        access(1'b1, 18'h00155, 16'hABCD, 2'h1, rd);
        access(1'b0, 18'h00155, 16'h0000, 2'h3, rd);
        check(rd, 16'h12CD);
        access(1'b0, 18'h00155, 16'h0000, 2'h1, rd);
        check(rd, 16'h00CD);
        access(1'b1, 18'h00155, 16'h9876, 2'h2, rd);
        access(1'b0, 18'h00155, 16'h0000, 2'h2, rd);
        check(rd, 16'h9800);
    endtask : t_lanes
    task automatic t_refuse;
        int n;
        logic seen;
        n = 0;
        seen = 1'b0;
        while (reqReady !== 1'b1) step(n);
        reqValid = 1'b1;
        reqLaneEn = 2'h0;
        step(n);
        reqValid = 1'b0;
        repeat (6) begin
            seen = seen | (rspValid !== 1'b0) | (chipSelect_n !== 1'b1);
            step(n);
        end
        check({15'h0000, seen}, 16'h0000);
    endtask : t_refuse
    initial begin
        repeat (10) @(posedge mclk);
        #1;
        arst_n = 1'b1;
        t_power;
        t_words;
        t_lanes;
        t_refuse;
        complete_run;
    end
endmodule : testbench
